// file: rtl/cis_alu.sv
`include "cis_cfg.svh"

module cis_alu (
  input  wire logic [4:0]  op_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic [31:0] aux_i,
  input  wire logic [4:0]  flags_i,
  input  wire logic        user_i,
  output logic      [31:0] res_o,
  output logic             take_o,
  output logic             fault_o
);

  function automatic logic [31:0] zx(input logic [31:0] v, input logic [1:0] s);
    case (s)
      2'h0:    zx = v & 32'h0000_00ff;
      2'h1:    zx = v & 32'h0000_ffff;
      default: zx = v;
    endcase
  endfunction

  logic [31:0] sq;
  logic [31:0] fm;
  logic [31:0] sum;
  logic [5:0]  flen;
  logic [4:0]  off;
  logic        ct;
  logic [1:0]  areg;

  // Short constant, sign extended before sizing
  assign sq   = {{28{aux_i[`CIS_AUX_SHORT+3]}}, aux_i[`CIS_AUX_SHORT +: 4]};
  assign flen = {1'b0, aux_i[`CIS_AUX_FLEN +: 5]} + 6'h01;
  assign off  = aux_i[`CIS_AUX_FOFF +: 5];
  assign fm   = flen[5] ? 32'hffff_ffff : ((32'h0000_0001 << flen) - 32'h0000_0001);
  assign sum  = zx(a_i + sq, size_i);
  assign areg = aux_i[`CIS_AUX_AREG +: 2];

  // Flags are {F, L, N, C, Z}
  always_comb begin
    case (aux_i[`CIS_AUX_COND +: 4])
      4'h0:    ct = flags_i[0];
      4'h1:    ct = !flags_i[0];
      4'h2:    ct = flags_i[1];
      4'h3:    ct = !flags_i[1];
      4'h4:    ct = flags_i[3];
      4'h5:    ct = !flags_i[3];
      4'h6:    ct = flags_i[2];
      4'h7:    ct = !flags_i[2];
      4'h8:    ct = flags_i[4];
      4'h9:    ct = !flags_i[4];
      4'ha:    ct = !flags_i[3] && !flags_i[0];
      4'hb:    ct = flags_i[3] || flags_i[0];
      4'hc:    ct = !flags_i[2] && !flags_i[0];
      4'hd:    ct = flags_i[2] || flags_i[0];
      4'he:    ct = 1'b1;
      default: ct = 1'b0;
    endcase
  end

  always_comb begin
    res_o  = `CIS_RST_WORD;
    take_o = 1'b0;
    case (op_i)
      cis_pkg::OP_QMOVE:   res_o = zx(sq, size_i);
      cis_pkg::OP_LSBINV:  res_o = zx(a_i ^ 32'h0000_0001, size_i);
      cis_pkg::OP_FULLINV: res_o = zx(~a_i, size_i);
      cis_pkg::OP_CSAVE:   res_o = {31'h0000_0000, ct};
      cis_pkg::OP_ACB: begin
        res_o  = sum;
        take_o = (sum != `CIS_RST_WORD);
      end
      cis_pkg::OP_FEXT:    res_o = (a_i >> off) & fm;
      cis_pkg::OP_FINS:    res_o = (a_i & ~(fm << off)) | ((b_i & fm) << off);
      cis_pkg::OP_PSWSET,
      cis_pkg::OP_PSWCLR:  res_o = zx(a_i, size_i);
      cis_pkg::OP_DIAG: begin
        res_o  = a_i;
        take_o = 1'b1;
      end
      default:             res_o = `CIS_RST_WORD;
    endcase
  end

  always_comb begin
    case (op_i)
      cis_pkg::OP_LPR,
      cis_pkg::OP_SPR:    fault_o = user_i && (areg == `CIS_AREG_PSW ||
                                               areg == `CIS_AREG_INTB);
      cis_pkg::OP_PSWSET,
      cis_pkg::OP_PSWCLR: fault_o = user_i && (size_i != 2'h0);
      cis_pkg::OP_TRET,
      cis_pkg::OP_IRET:   fault_o = user_i;
      cis_pkg::OP_CFGW:   fault_o = user_i;
      default:            fault_o = 1'b0;
    endcase
  end

endmodule

// file: rtl/cis_cfg.svh
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

// Register byte offsets
`define CIS_OFF_CTRL   8'h00
`define CIS_OFF_OPA    8'h04
`define CIS_OFF_OPB    8'h08
`define CIS_OFF_AUX    8'h0c
`define CIS_OFF_RES    8'h24
`define CIS_OFF_STAT   8'h28
`define CIS_OFF_MODE   8'h2c
`define CIS_OFF_MEMA   8'h30
`define CIS_OFF_MEMD   8'h34
`define CIS_OFF_PSW    8'h38
`define CIS_OFF_INTB   8'h3c
`define CIS_OFF_CFG    8'h40
// General registers R0..R4 at word index 4..8
`define CIS_GPR_LO     4'h4
`define CIS_GPR_HI     4'h8

// Control word fields
`define CIS_CTL_OP     0
`define CIS_CTL_BWD    5
`define CIS_CTL_MATCH  6
`define CIS_CTL_SIZE   8

// Auxiliary operand fields
`define CIS_AUX_SHORT  0
`define CIS_AUX_COND   4
`define CIS_AUX_FOFF   8
`define CIS_AUX_FLEN   13
`define CIS_AUX_AREG   18
`define CIS_AUX_DISP   20

// Special register selects and limits
`define CIS_AREG_PSW   2'h0
`define CIS_AREG_INTB  2'h1
`define CIS_PSW_U      8
`define CIS_DISP_MAX   5'h10

// Reset values
`define CIS_RST_WORD   32'h0000_0000

`endif

// file: rtl/cis_exec.sv
// Behaviour
// - String ops use R4 compare value, R3 table, R2/R1 pointers, R0 count.
// - Backward option decrements both string pointers after each element.
// - Until option stops when string 1 element equals R4.
// - While option stops when string 1 element differs from R4.
// - Each element decrements R0; operation ends when R0 reaches zero.
// - Translating variants map string 1 bytes through table at R3 first.
// - Multi-byte compare compares blocks of 1 to 16 bytes.
// - Boolean invert flips only bit 0; full invert flips all bits.
// - Condition save writes condition truth as a sized boolean.
// - Add-compare-branch adds signed 4-bit constant, branches when nonzero.
// - Field extract right-aligns a field; insert writes aligned value into field.
// - Locked set/clear bit is one unsplittable read-modify-write.
// - Special register load/store of status or table base needs privilege.
// - Status bit set/clear in user mode allowed only for byte size.
// - Trap and interrupt return need privileged mode.
// - Configuration write needs privileged mode.
// - Diagnose acts as a branch to its own address.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`include "cis_cfg.svh"

module cis_exec (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o,
  output logic             trap_o,
  output logic             lock_o
);

  cis_pkg::cis_regs_type r;
  cis_pkg::cis_regs_type n;

  logic [7:0]  bus_off;
  logic [3:0]  bus_wix;
  logic [2:0]  gix;
  logic        is_gpr;
  logic        bus_req;
  logic        mem_wait;
  logic [31:0] alu_res;
  logic        alu_take;
  logic        fault;
  logic        is_str;
  logic        is_xl;
  logic [5:0]  p1;
  logic [5:0]  p2;
  logic [7:0]  raw;
  logic [7:0]  elem;
  logic        hit;
  logic        str_stop;
  logic        str_step;
  logic [7:0]  ca;
  logic [7:0]  cb;
  logic [5:0]  tidx;
  logic [2:0]  bidx;
  logic [4:0]  dlen;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  assign bus_off  = {wb_adr_i[7:2], 2'b00};
  assign bus_wix  = wb_adr_i[5:2];
  assign is_gpr   = (wb_adr_i[7:6] == 2'b00) && (bus_wix >= `CIS_GPR_LO) &&
                    (bus_wix <= `CIS_GPR_HI);
  assign gix      = 3'(bus_wix - `CIS_GPR_LO);
  assign bus_req  = wb_cyc_i && wb_stb_i && !r.ack;
  // Memory port stalls during a locked cycle so no access splits it
  assign mem_wait = r.lock && (bus_off == `CIS_OFF_MEMD);

  assign is_xl  = (r.op == cis_pkg::OP_XMOVS) || (r.op == cis_pkg::OP_XCMPS) ||
                  (r.op == cis_pkg::OP_XSKPS);
  assign is_str = is_xl || (r.op == cis_pkg::OP_MOVS) || (r.op == cis_pkg::OP_CMPS) ||
                  (r.op == cis_pkg::OP_SKPS);

  // Fixed register roles of string operations
  assign p1   = r.gpr[1][5:0];
  assign p2   = r.gpr[2][5:0];
  assign raw  = r.mem[p1];
  assign elem = is_xl ? r.mem[6'(r.gpr[3][5:0] + raw[5:0])] : raw;
  assign hit  = (elem == r.gpr[4][7:0]);
  assign str_stop = ((r.mt == cis_pkg::M_UNTIL) && hit) ||
                    ((r.mt == cis_pkg::M_WHILE) && !hit);

  assign ca   = r.mem[r.opa[5:0]];
  assign cb   = r.mem[r.opb[5:0]];
  assign tidx = 6'(r.opb[5:0] + r.opa[8:3]);
  assign bidx = r.opa[2:0];
  assign dlen = r.aux[`CIS_AUX_DISP +: 5];

  cis_alu u_alu (
    .op_i    (r.op),
    .size_i  (r.sz),
    .a_i     (r.opa),
    .b_i     (r.opb),
    .aux_i   (r.aux),
    .flags_i ({r.ff, r.fl, r.fn, r.fc, r.fz}),
    .user_i  (r.user),
    .res_o   (alu_res),
    .take_o  (alu_take),
    .fault_o (fault)
  );

  always_comb begin
    n        = r;
    str_step = 1'b0;
    n.ack    = 1'b0;
    n.dat    = `CIS_RST_WORD;
    if (bus_req && !mem_wait) begin
      n.ack = 1'b1;
      if (is_gpr) begin
        n.dat = r.gpr[gix];
      end else begin
        case (bus_off)
          `CIS_OFF_CTRL: n.dat = {22'h00_0000, r.sz, r.mt, r.bwd, r.op};
          `CIS_OFF_OPA:  n.dat = r.opa;
          `CIS_OFF_OPB:  n.dat = r.opb;
          `CIS_OFF_AUX:  n.dat = r.aux;
          `CIS_OFF_RES:  n.dat = r.res;
          `CIS_OFF_STAT: n.dat = {28'h000_0000, r.done, r.brk, r.trap, r.busy};
          `CIS_OFF_MODE: n.dat = {26'h000_0000, r.ff, r.fl, r.fn, r.fc, r.fz, r.user};
          `CIS_OFF_MEMA: n.dat = {26'h000_0000, r.mema};
          `CIS_OFF_MEMD: n.dat = {24'h00_0000, r.mem[r.mema]};
          `CIS_OFF_PSW:  n.dat = r.psw;
          `CIS_OFF_INTB: n.dat = r.intb;
          `CIS_OFF_CFG:  n.dat = r.cfg;
          default:       n.dat = `CIS_RST_WORD;
        endcase
      end
      // Writes while busy are acknowledged but dropped
      if (wb_we_i && !r.busy) begin
        if (is_gpr) begin
          n.gpr[gix] = wmerge(r.gpr[gix], wb_dat_i, wb_sel_i);
        end else begin
          case (bus_off)
            `CIS_OFF_CTRL: begin
              if (wb_sel_i[0]) begin
                n.op   = cis_pkg::cis_op_type'(wb_dat_i[`CIS_CTL_OP +: 5]);
                n.bwd  = wb_dat_i[`CIS_CTL_BWD];
                n.mt   = cis_pkg::cis_match_type'(wb_dat_i[`CIS_CTL_MATCH +: 2]);
                n.sz   = wb_dat_i[`CIS_CTL_SIZE +: 2];
                n.st   = cis_pkg::S_DISP;
                n.busy = 1'b1;
                n.trap = 1'b0;
                n.brk  = 1'b0;
                n.done = 1'b0;
              end
            end
            `CIS_OFF_OPA: n.opa = wmerge(r.opa, wb_dat_i, wb_sel_i);
            `CIS_OFF_OPB: n.opb = wmerge(r.opb, wb_dat_i, wb_sel_i);
            `CIS_OFF_AUX: n.aux = wmerge(r.aux, wb_dat_i, wb_sel_i);
            `CIS_OFF_MODE: begin
              if (wb_sel_i[0]) begin
                {n.ff, n.fl, n.fn, n.fc, n.fz, n.user} = wb_dat_i[5:0];
              end
            end
            `CIS_OFF_MEMA: begin
              if (wb_sel_i[0]) begin
                n.mema = wb_dat_i[5:0];
              end
            end
            `CIS_OFF_MEMD: begin
              if (wb_sel_i[0]) begin
                n.mem[r.mema] = wb_dat_i[7:0];
              end
            end
            default: ;
          endcase
        end
      end
    end

    case (r.st)
      cis_pkg::S_IDLE: ;
      cis_pkg::S_DISP: begin
        n.st   = cis_pkg::S_IDLE;
        n.busy = 1'b0;
        n.done = 1'b1;
        if (fault) begin
          n.trap = 1'b1;
        end else begin
          case (r.op)
            cis_pkg::OP_QMOVE, cis_pkg::OP_LSBINV, cis_pkg::OP_FULLINV,
            cis_pkg::OP_CSAVE, cis_pkg::OP_ACB, cis_pkg::OP_FEXT,
            cis_pkg::OP_FINS, cis_pkg::OP_DIAG: begin
              n.res = alu_res;
              n.brk = alu_take;
            end
            cis_pkg::OP_LPR: begin
              if (r.aux[`CIS_AUX_AREG +: 2] == `CIS_AREG_PSW) begin
                n.psw = r.opa;
              end else if (r.aux[`CIS_AUX_AREG +: 2] == `CIS_AREG_INTB) begin
                n.intb = r.opa;
              end
            end
            cis_pkg::OP_SPR: begin
              case (r.aux[`CIS_AUX_AREG +: 2])
                `CIS_AREG_PSW:  n.res = r.psw;
                `CIS_AREG_INTB: n.res = r.intb;
                default:        n.res = `CIS_RST_WORD;
              endcase
            end
            cis_pkg::OP_PSWSET: n.psw = r.psw | alu_res;
            cis_pkg::OP_PSWCLR: n.psw = r.psw & ~alu_res;
            cis_pkg::OP_TRET,
            cis_pkg::OP_IRET: n.user = r.psw[`CIS_PSW_U];
            cis_pkg::OP_CFGW: n.cfg = r.opa;
            cis_pkg::OP_CMPM: begin
              if (dlen == 5'h00 || dlen > `CIS_DISP_MAX) begin
                n.trap = 1'b1;
              end else begin
                n.st   = cis_pkg::S_CMPM;
                n.busy = 1'b1;
                n.done = 1'b0;
                n.cnt  = dlen;
              end
            end
            cis_pkg::OP_MOVS, cis_pkg::OP_CMPS, cis_pkg::OP_SKPS,
            cis_pkg::OP_XMOVS, cis_pkg::OP_XCMPS, cis_pkg::OP_XSKPS: begin
              // Zero count ends here, before any memory access
              if (r.gpr[0] != `CIS_RST_WORD) begin
                n.st   = cis_pkg::S_STR;
                n.busy = 1'b1;
                n.done = 1'b0;
              end
            end
            cis_pkg::OP_LSET, cis_pkg::OP_LCLR: begin
              n.st   = cis_pkg::S_LKRD;
              n.busy = 1'b1;
              n.done = 1'b0;
              n.lock = 1'b1;
            end
            default: ;
          endcase
        end
      end
      cis_pkg::S_STR: begin
        if (str_stop) begin
          n.ff   = 1'b1;
          n.st   = cis_pkg::S_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
        end else if ((r.op == cis_pkg::OP_CMPS || r.op == cis_pkg::OP_XCMPS) &&
                     elem != r.mem[p2]) begin
          n.fz   = 1'b0;
          n.fl   = elem > r.mem[p2];
          n.fn   = $signed(elem) > $signed(r.mem[p2]);
          n.st   = cis_pkg::S_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
        end else begin
          str_step = 1'b1;
          n.ff     = 1'b0;
          n.fz     = 1'b1;
          if (r.op == cis_pkg::OP_MOVS || r.op == cis_pkg::OP_XMOVS) begin
            n.mem[p2] = elem;
          end
          if (r.bwd) begin
            n.gpr[1] = r.gpr[1] - 32'h0000_0001;
            n.gpr[2] = r.gpr[2] - 32'h0000_0001;
          end else begin
            n.gpr[1] = r.gpr[1] + 32'h0000_0001;
            n.gpr[2] = r.gpr[2] + 32'h0000_0001;
          end
          n.gpr[0] = r.gpr[0] - 32'h0000_0001;
          if (r.gpr[0] == 32'h0000_0001) begin
            n.st   = cis_pkg::S_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
          end
        end
      end
      cis_pkg::S_CMPM: begin
        if (ca != cb) begin
          n.fz   = 1'b0;
          n.fl   = ca > cb;
          n.fn   = $signed(ca) > $signed(cb);
          n.st   = cis_pkg::S_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
        end else begin
          n.opa = r.opa + 32'h0000_0001;
          n.opb = r.opb + 32'h0000_0001;
          n.cnt = r.cnt - 5'h01;
          if (r.cnt == 5'h01) begin
            n.fz   = 1'b1;
            n.st   = cis_pkg::S_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
          end
        end
      end
      cis_pkg::S_LKRD: begin
        n.ff = r.mem[tidx][bidx];
        n.st = cis_pkg::S_LKWR;
      end
      cis_pkg::S_LKWR: begin
        n.mem[tidx][bidx] = (r.op == cis_pkg::OP_LSET);
        n.lock = 1'b0;
        n.st   = cis_pkg::S_IDLE;
        n.busy = 1'b0;
        n.done = 1'b1;
      end
      default: begin
        n.st   = cis_pkg::S_IDLE;
        n.busy = 1'b0;
        n.lock = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r    <= '0;
      r.st <= cis_pkg::S_IDLE;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign busy_o   = r.busy;
  assign trap_o   = r.trap;
  assign lock_o   = r.lock;

  AST_EMPTY_STR: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (r.st == cis_pkg::S_DISP && is_str && !fault && r.gpr[0] == `CIS_RST_WORD)
    |=> (r.st == cis_pkg::S_IDLE && r.done && r.gpr == $past(r.gpr)))
    else $error("empty string op did not finish cleanly");

  AST_COUNT_DEC: assert property (
    @(posedge clk_i) disable iff (rst_i)
    str_step |=> r.gpr[0] == $past(r.gpr[0]) - 32'h0000_0001)
    else $error("string count not decremented");

  AST_BACKWARD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (str_step && r.bwd)
    |=> (r.gpr[1] == $past(r.gpr[1]) - 32'h0000_0001 &&
         r.gpr[2] == $past(r.gpr[2]) - 32'h0000_0001))
    else $error("backward pointers not decremented");

  AST_UNTIL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (r.st == cis_pkg::S_STR && r.mt == cis_pkg::M_UNTIL && hit)
    |=> (r.st == cis_pkg::S_IDLE && r.ff && r.gpr[0] == $past(r.gpr[0])))
    else $error("until match did not stop");

  AST_WHILE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (r.st == cis_pkg::S_STR && r.mt == cis_pkg::M_WHILE && !hit)
    |=> (r.st == cis_pkg::S_IDLE && r.ff))
    else $error("while mismatch did not stop");

  AST_LOCKED: assert property (
    @(posedge clk_i) disable iff (rst_i)
    r.st == cis_pkg::S_LKRD
    |=> (r.lock && r.st == cis_pkg::S_LKWR) ##1 (!r.lock && r.st == cis_pkg::S_IDLE))
    else $error("locked cycle broken");

  AST_PRIV_TRAP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (r.st == cis_pkg::S_DISP && fault)
    |=> (r.trap && r.psw == $past(r.psw) && r.intb == $past(r.intb) &&
         r.user == $past(r.user) && r.cfg == $past(r.cfg)))
    else $error("privileged op not trapped");

  AST_DIAG: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (r.st == cis_pkg::S_DISP && r.op == cis_pkg::OP_DIAG)
    |=> (r.brk && r.res == $past(r.opa)))
    else $error("diagnose not a self branch");

  AST_QMOVE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (r.st == cis_pkg::S_DISP && r.op == cis_pkg::OP_QMOVE && r.sz == 2'h3 && !r.user)
    |=> r.res == {{28{$past(r.aux[3])}}, $past(r.aux[3:0])})
    else $error("quick move not sign extended");

  AST_CMPM_LEN: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (r.st == cis_pkg::S_DISP && r.op == cis_pkg::OP_CMPM &&
     (dlen == 5'h00 || dlen > `CIS_DISP_MAX))
    |=> (r.trap && r.st == cis_pkg::S_IDLE))
    else $error("bad compare length accepted");

endmodule

// file: rtl/cis_pkg.sv
package cis_pkg;

  typedef enum logic [4:0] {
    OP_NOP     = 5'h00,
    OP_QMOVE   = 5'h01,
    OP_CMPM    = 5'h02,
    OP_LSBINV  = 5'h03,
    OP_FULLINV = 5'h04,
    OP_CSAVE   = 5'h05,
    OP_ACB     = 5'h06,
    OP_FEXT    = 5'h07,
    OP_FINS    = 5'h08,
    OP_MOVS    = 5'h09,
    OP_CMPS    = 5'h0a,
    OP_SKPS    = 5'h0b,
    OP_XMOVS   = 5'h0c,
    OP_XCMPS   = 5'h0d,
    OP_XSKPS   = 5'h0e,
    OP_LSET    = 5'h0f,
    OP_LCLR    = 5'h10,
    OP_LPR     = 5'h11,
    OP_SPR     = 5'h12,
    OP_PSWSET  = 5'h13,
    OP_PSWCLR  = 5'h14,
    OP_TRET    = 5'h15,
    OP_IRET    = 5'h16,
    OP_CFGW    = 5'h17,
    OP_DIAG    = 5'h18
  } cis_op_type;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DISP = 6'h02,
    S_STR  = 6'h04,
    S_CMPM = 6'h08,
    S_LKRD = 6'h10,
    S_LKWR = 6'h20
  } cis_state_type;

  typedef enum logic [1:0] {
    M_NONE  = 2'h0,
    M_UNTIL = 2'h1,
    M_WHILE = 2'h2
  } cis_match_type;

  typedef struct packed {
    cis_state_type      st;
    cis_op_type         op;
    logic               bwd;
    cis_match_type      mt;
    logic [1:0]         sz;
    logic [4:0][31:0]   gpr;
    logic [63:0][7:0]   mem;
    logic [31:0]        opa;
    logic [31:0]        opb;
    logic [31:0]        aux;
    logic [31:0]        res;
    logic [31:0]        psw;
    logic [31:0]        intb;
    logic [31:0]        cfg;
    logic [5:0]         mema;
    logic [4:0]         cnt;
    logic               user;
    logic               fz;
    logic               fc;
    logic               fn;
    logic               fl;
    logic               ff;
    logic               busy;
    logic               trap;
    logic               brk;
    logic               done;
    logic               lock;
    logic               ack;
    logic [31:0]        dat;
  } cis_regs_type;

endpackage

// file: testbench/cis_exec_tb_top.sv
`include "cis_cfg.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end

module cis_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        busy_o;
  logic        trap_o;
  logic        lock_o;
  logic [31:0] q;
  logic        lock_seen;
  int          mismatches;
  int          compares;

  cis_exec i_cis_exec (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .trap_o(trap_o),
    .lock_o(lock_o));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Sticky so a short locked window is not missed between polls
  always @(posedge clk_i) begin
    if (lock_o === 1'b1) lock_seen <= 1'b1;
  end

  task automatic end_sim();
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ack is read before its edge updates land, so it is the sampled value
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(n, e, q)
  endtask

  task automatic run(input logic [1:0] sz, input logic [1:0] mt, input logic [4:0] op,
                     input logic b = 1'b0);
    int n;
    wr(`CIS_OFF_CTRL, {22'h0, sz, mt, b, op});
    n = 0;
    do begin
      wb(1'b0, `CIS_OFF_STAT, 32'h0000_0000, q);
      n++;
    end while (q[3] !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
  endtask

  task automatic mem(input logic [7:0] a, input logic [31:0] e, input string n);
    wr(`CIS_OFF_MEMA, {24'h0, a});
    rd(`CIS_OFF_MEMD, e, n);
  endtask

  initial begin
    wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_sel_i = 4'h0; wb_dat_i = 32'h0000_0000; rst_i = 1'b1; lock_seen = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`CIS_OFF_STAT, 32'h0000_0000, "status reset");
    rd(`CIS_OFF_MODE, 32'h0000_0000, "mode reset");
    rd(8'h50, 32'h0000_0000, "unmapped read");
    wr(`CIS_OFF_AUX, 32'h0000_000F);
    run(2'h1, 2'h0, cis_pkg::OP_QMOVE);
    rd(`CIS_OFF_RES, 32'h0000_FFFF, "quick move");
    wr(`CIS_OFF_OPA, 32'h0000_00F0);
    run(2'h0, 2'h0, cis_pkg::OP_LSBINV);
    rd(`CIS_OFF_RES, 32'h0000_00F1, "lsb invert");
    run(2'h0, 2'h0, cis_pkg::OP_FULLINV);
    rd(`CIS_OFF_RES, 32'h0000_000F, "full invert");
    wr(`CIS_OFF_OPA, 32'h0000_0001);
    run(2'h3, 2'h0, cis_pkg::OP_ACB);
    rd(`CIS_OFF_RES, 32'h0000_0000, "acb sum");
    rd(`CIS_OFF_STAT, 32'h0000_0008, "acb no branch");
    wr(`CIS_OFF_OPA, 32'h0000_0F00);
    wr(`CIS_OFF_AUX, 32'h0000_6800);
    run(2'h3, 2'h0, cis_pkg::OP_FEXT);
    rd(`CIS_OFF_RES, 32'h0000_000F, "extract");
    wr(`CIS_OFF_OPA, 32'h0000_0040);
    run(2'h0, 2'h0, cis_pkg::OP_DIAG);
    rd(`CIS_OFF_RES, 32'h0000_0040, "diag target");
    rd(`CIS_OFF_STAT, 32'h0000_000C, "diag brk");
    for (int i = 0; i < 3; i++) begin
      wr(`CIS_OFF_MEMA, i);
      wr(`CIS_OFF_MEMD, 32'h0000_0011 * (i + 1));
    end
    wr(8'h10, 32'h0000_0003);
    wr(8'h14, 32'h0000_0000);
    wr(8'h18, 32'h0000_0018);
    wr(8'h20, 32'h0000_0022);
    // Stops in front of the second byte, which matches the compare value
    run(2'h0, 2'h1, cis_pkg::OP_MOVS);
    mem(8'h18, 32'h0000_0011, "until first copy");
    mem(8'h19, 32'h0000_0000, "until stop");
    rd(8'h10, 32'h0000_0002, "until count");
    wr(8'h10, 32'h0000_0000);
    run(2'h0, 2'h0, cis_pkg::OP_MOVS);
    rd(8'h14, 32'h0000_0001, "zero count ptr");
    wr(8'h10, 32'h0000_0002);
    run(2'h0, 2'h0, cis_pkg::OP_MOVS);
    rd(8'h10, 32'h0000_0000, "count done");
    mem(8'h1A, 32'h0000_0033, "copy second");
    wr(`CIS_OFF_OPA, 32'h0000_0003);
    wr(`CIS_OFF_OPB, 32'h0000_0020);
    run(2'h0, 2'h0, cis_pkg::OP_LSET);
    mem(8'h20, 32'h0000_0008, "locked set");
    `CHK("lock seen", 1'b1, lock_seen)
    // Backward while: first element matches, second ends the run
    wr(8'h10, 32'h0000_0003);
    wr(8'h14, 32'h0000_0002);
    wr(8'h18, 32'h0000_002A);
    wr(8'h20, 32'h0000_0033);
    run(2'h0, 2'h2, cis_pkg::OP_MOVS, 1'b1);
    mem(8'h2A, 32'h0000_0033, "backward copy");
    rd(8'h14, 32'h0000_0001, "backward ptr1");
    rd(8'h18, 32'h0000_0029, "backward ptr2");
    rd(8'h10, 32'h0000_0002, "while count");
    // Byte 0x11 indexes table entry 0x20, left by the locked set
    wr(8'h10, 32'h0000_0001);
    wr(8'h14, 32'h0000_0000);
    wr(8'h18, 32'h0000_0030);
    wr(8'h1C, 32'h0000_000F);
    run(2'h0, 2'h0, cis_pkg::OP_XMOVS);
    mem(8'h30, 32'h0000_0008, "translate");
    wr(`CIS_OFF_OPA, 32'h0000_0018);
    wr(`CIS_OFF_OPB, 32'h0000_002A);
    wr(`CIS_OFF_AUX, 32'h0030_0000);
    run(2'h0, 2'h0, cis_pkg::OP_CMPM);
    rd(`CIS_OFF_MODE, 32'h0000_0000, "cmpm differ");
    wr(`CIS_OFF_OPB, 32'h0000_0000);
    run(2'h0, 2'h0, cis_pkg::OP_CMPM);
    rd(`CIS_OFF_MODE, 32'h0000_0002, "cmpm equal");
    wr(`CIS_OFF_AUX, 32'h0000_0008);
    run(2'h0, 2'h0, cis_pkg::OP_CMPM);
    rd(`CIS_OFF_STAT, 32'h0000_000A, "cmpm zero len");
    run(2'h3, 2'h0, cis_pkg::OP_QMOVE);
    rd(`CIS_OFF_RES, 32'hFFFF_FFF8, "quick move dword");
    run(2'h0, 2'h0, cis_pkg::OP_CSAVE);
    rd(`CIS_OFF_RES, 32'h0000_0001, "cond save");
    wr(`CIS_OFF_MODE, 32'h0000_0001);
    wr(`CIS_OFF_OPA, 32'h0000_0005);
    run(2'h0, 2'h0, cis_pkg::OP_CFGW);
    `CHK("cfg trap", 1'b1, trap_o)
    rd(`CIS_OFF_CFG, 32'h0000_0000, "cfg kept");
    run(2'h0, 2'h0, cis_pkg::OP_PSWSET);
    `CHK("psw byte", 1'b0, trap_o)
    run(2'h1, 2'h0, cis_pkg::OP_PSWSET);
    `CHK("psw word", 1'b1, trap_o)
    run(2'h0, 2'h0, cis_pkg::OP_TRET);
    `CHK("trap return", 1'b1, trap_o)
    `CHK("idle", 1'b0, busy_o)
    end_sim();
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
endmodule
